// *** hdl/dpsrc_top.sv ***
/*
 * Parameter memory handling, drive-ready and online control for a motor drive.
 * Assumes pins are asynchronous to ref_clk and the register master follows the
 * one-cycle strobe protocol; resetn is the power-on reset.
 */
// Local design decisions: the register addresses and the plain strobed port.
`default_nettype none
// Functional notes
// [R1] After reset, working memory is loaded from the active permanent bank.
// [R2] Save command value 1 copies working memory into the active bank.
// [R3] Load-stored value 1 overwrites working memory from the active bank.
// [R4] Load-defaults value 1 overwrites working memory with default values.
// [R5] Save always allowed; loads need drive stopped; all loads but the factory restore also need reserved key open.
// [R6] Every save is read back and compared; mismatch raises verify alarm.
// [R7] Two permanent banks; active bank setting 0 or 1 selects which.
// [R8] Bank input change updates bank setting, then reloads from that bank.
// [R9] Bank switching from the bank input only happens while the drive is off and not running.
// [R10] Load-stored value 2 starts a restore from the factory image.
// [R11] Matching firmware revision: core words restored from factory image, ignoring key.
// [R12] Differing revision: core words default except protected ones keep factory values.
// [R13] Every factory restore returns application words to defaults.
// [R14] Invalid factory image raises factory alarm and loads all defaults.
// [R15] Ready high only with no alarm, software enable 1, external enable high.
// [R16] Ready held low after alarm until causes gone and alarm reset applied.
// [R17] Alarm reset acts only on the rising edge of the reset function.
// [R18] Online only when ready, run input high and software run enable 1.
// [R19] Alarm enable mask is sixteen bits, all ones after reset.
// [R20] Display goes idle after 3 to 20 seconds inactivity, default 10.
// [R21] Reserved words writable only while the access key matches the stored key.
// [R22] Memory commands clear to 0 once done or alarmed.
module dpsrc_top #(
	parameter int CYCLES_PER_SEC_P = dpsrc_pkg::CYCLES_PER_SEC
) (
	input  wire logic               ref_clk,
	input  wire logic               resetn,
	input  wire dpsrc_pkg::dpsrc_bus_t  bus,
	input  wire dpsrc_pkg::dpsrc_pins_t pins,
	output logic [15:0]             rdata,
	output logic                    ready,
	output logic                    online,
	output logic                    busy,
	output logic                    display_idle
);
	import dpsrc_pkg::*;

	typedef struct packed {
		dpsrc_state_t      state;
		dpsrc_op_t         op;
		logic [3:0]        idx;
		logic              verr;
		dpsrc_mem_t        work;
		logic [1:0][NW-1:0][15:0] bank;
		dpsrc_mem_t        fact;
		logic              fact_valid;
		dpsrc_word_t       fact_rev;
		logic              bank_sel;
		logic              load_def;
		logic [1:0]        load_stored;
		logic              save;
		logic              capt;
		logic              sw_en;
		logic              run_en;
		logic              rst_cmd;
		dpsrc_word_t       key;
		dpsrc_word_t       mask;
		logic [4:0]        disp_time;
		logic [3:0]        paddr;
		logic              refused;
		logic              alm_verify;
		logic              alm_factory;
		logic              block;
		logic              rst_q;
		dpsrc_pins_t       s1;
		dpsrc_pins_t       s2;
		logic              bk_prev;
		logic              bk_pend;
		logic [26:0]       tick;
		logic [4:0]        secs;
		logic              idle;
		logic              ready;
		logic              online;
		logic              busy;
		dpsrc_word_t       rdata;
	} dpsrc_st_t;

	dpsrc_st_t st;
	dpsrc_st_t next_st;
	logic      rst_fn;
	logic      rst_edge;
	logic      causes;
	logic      alarm_act;
	logic      key_open;
	logic      stopped;
	dpsrc_word_t alarm_vec;

	assign rst_fn    = st.s2.alarm_reset | st.rst_cmd;
	assign rst_edge  = rst_fn & ~st.rst_q; // [R17]
	assign causes    = |({st.s2.alarm_cause, 2'b00} & st.mask);
	assign alarm_vec = {st.s2.alarm_cause, st.alm_factory, st.alm_verify};
	assign alarm_act = |(alarm_vec & st.mask);
	assign key_open  = (st.key == KEY_VALUE); // [R21]
	assign stopped   = ~st.online;

	function automatic dpsrc_word_t fact_word(input dpsrc_st_t s, input logic [3:0] i);
		if (!s.fact_valid)
			fact_word = default_word(i); // [R14]
		else if (!CORE_MASK[i])
			fact_word = default_word(i); // [R13]
		else if (s.fact_rev == FW_REV || PROTECT_MASK[i])
			fact_word = s.fact[i]; // [R11] [R12]
		else
			fact_word = default_word(i); // [R12]
	endfunction : fact_word

	always_comb begin
		next_st = st;
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.rst_q = rst_fn;
		next_st.bk_prev = st.s2.bank_switch_input;
		if (st.s2.bank_switch_input != st.bk_prev)
			next_st.bk_pend = 1'b1; // [R8]
		if (rst_edge)
			next_st.rst_cmd = 1'b0;

		// Memory sequencer
		unique case (st.state)
			ST_IDLE: begin
				next_st.idx = 4'h0;
				next_st.verr = 1'b0;
				if (st.save) begin
					next_st.op = OP_SAVE; // [R2] [R5]
					next_st.state = ST_COPY;
					next_st.refused = 1'b0;
				end else if (st.load_stored == LS_FACTORY) begin
					if (stopped) begin
						next_st.op = OP_FACT; // [R10]
						next_st.state = ST_COPY;
						next_st.refused = 1'b0;
						if (!st.fact_valid)
							next_st.alm_factory = 1'b1; // [R14]
					end else begin
						next_st.load_stored = 2'h0;
						next_st.refused = 1'b1;
					end
				end else if (st.load_stored != 2'h0 || st.load_def) begin
					if (stopped && key_open && st.load_stored != 2'h3) begin // [R5]
						next_st.op = (st.load_stored == LS_NV) ? OP_LOAD_NV : OP_LOAD_DEF; // [R3] [R4]
						next_st.state = ST_COPY;
						next_st.refused = 1'b0;
					end else begin
						next_st.load_stored = 2'h0;
						next_st.load_def = 1'b0;
						next_st.refused = 1'b1;
					end
				end else if (st.capt) begin
					next_st.op = OP_CAPT;
					next_st.state = ST_COPY;
				end else if (st.bk_pend && stopped && !st.ready) begin // [R9]
					next_st.bk_pend = 1'b0;
					next_st.bank_sel = st.s2.bank_switch_input; // [R8]
					next_st.op = OP_LOAD_NV;
					next_st.state = ST_COPY;
				end
			end
			ST_COPY: begin
				unique case (st.op)
					OP_BOOT, OP_LOAD_NV: next_st.work[st.idx] = st.bank[st.bank_sel][st.idx]; // [R1] [R3] [R7]
					OP_LOAD_DEF:         next_st.work[st.idx] = default_word(st.idx); // [R4]
					OP_SAVE:             next_st.bank[st.bank_sel][st.idx] = st.work[st.idx]; // [R2] [R7]
					OP_FACT:             next_st.work[st.idx] = fact_word(st, st.idx);
					OP_CAPT:             next_st.fact[st.idx] = st.work[st.idx];
				endcase
				next_st.idx = st.idx + 4'h1;
				if (st.idx == 4'hF) begin
					next_st.state = (st.op == OP_SAVE) ? ST_VERIFY : ST_IDLE;
					if (st.op == OP_CAPT) begin
						next_st.fact_valid = 1'b1;
						next_st.capt = 1'b0;
					end
					if (st.op == OP_LOAD_NV || st.op == OP_FACT)
						next_st.load_stored = 2'h0; // [R22]
					if (st.op == OP_LOAD_DEF)
						next_st.load_def = 1'b0; // [R22]
				end
			end
			ST_VERIFY: begin
				if (st.bank[st.bank_sel][st.idx] != st.work[st.idx])
					next_st.verr = 1'b1; // [R6]
				next_st.idx = st.idx + 4'h1;
				if (st.idx == 4'hF) begin
					next_st.state = ST_IDLE;
					next_st.save = 1'b0; // [R22]
					if (next_st.verr)
						next_st.alm_verify = 1'b1; // [R6]
				end
			end
		endcase

		// Alarm reset and ready latch
		if (rst_edge) begin
			next_st.alm_verify = next_st.alm_verify & (st.state == ST_VERIFY && next_st.state == ST_IDLE);
			next_st.alm_factory = next_st.alm_factory & (st.state == ST_IDLE && next_st.state == ST_COPY);
			if (!causes)
				next_st.block = 1'b0; // [R16]
		end
		if (|({st.s2.alarm_cause, next_st.alm_factory, next_st.alm_verify} & st.mask))
			next_st.block = 1'b1; // [R16]
		next_st.ready = ~alarm_act & ~st.block & st.sw_en & st.s2.ext_enable; // [R15]
		next_st.online = next_st.ready & st.s2.run_cmd & st.run_en; // [R18]
		next_st.busy = (next_st.state != ST_IDLE);

		// Display inactivity timer
		if (bus.wr || bus.rd) begin
			next_st.tick = 27'h0;
			next_st.secs = 5'h0;
			next_st.idle = 1'b0;
		end else if (st.tick == 27'(CYCLES_PER_SEC_P - 1)) begin
			next_st.tick = 27'h0;
			if (st.secs < DISP_MAX_S)
				next_st.secs = st.secs + 5'h1;
		end else begin
			next_st.tick = st.tick + 27'h1;
		end
		if (!(bus.wr || bus.rd) && st.secs >= st.disp_time)
			next_st.idle = 1'b1; // [R20]

		// Register writes; a write landing with a sequencer clear wins
		if (bus.wr) begin
			unique case (bus.addr)
				REG_CTRL: begin
					next_st.sw_en = bus.wdata[CTRL_SW_EN];
					next_st.run_en = bus.wdata[CTRL_RUN_EN];
					next_st.rst_cmd = bus.wdata[CTRL_AL_RST];
				end
				REG_LOAD_DEF:    next_st.load_def = bus.wdata[0];
				REG_LOAD_STORED: next_st.load_stored = bus.wdata[1:0];
				REG_SAVE:        next_st.save = bus.wdata[0];
				REG_BANK:        if (st.state == ST_IDLE) next_st.bank_sel = bus.wdata[0];
				REG_KEY:         next_st.key = bus.wdata;
				REG_ALM_MASK:    next_st.mask = bus.wdata; // [R19]
				REG_DISP_TIME: begin
					if (bus.wdata < 16'(DISP_MIN_S))
						next_st.disp_time = DISP_MIN_S; // [R20]
					else if (bus.wdata > 16'(DISP_MAX_S))
						next_st.disp_time = DISP_MAX_S;
					else
						next_st.disp_time = bus.wdata[4:0];
				end
				REG_PADDR:       next_st.paddr = bus.wdata[3:0];
				REG_PDATA: begin
					if (st.state == ST_IDLE && (!RESERVED_MASK[st.paddr] || key_open))
						next_st.work[st.paddr] = bus.wdata; // [R21]
				end
				REG_FACT_REV:    next_st.fact_rev = bus.wdata;
				REG_FACT_CAPT:   next_st.capt = bus.wdata[0];
				default: ;
			endcase
		end

		next_st.rdata = 16'h0000;
		if (bus.rd) begin
			unique case (bus.addr)
				REG_CTRL:        next_st.rdata = {13'h0000, st.rst_cmd, st.run_en, st.sw_en};
				REG_LOAD_DEF:    next_st.rdata = {15'h0000, st.load_def};
				REG_LOAD_STORED: next_st.rdata = {14'h0000, st.load_stored};
				REG_SAVE:        next_st.rdata = {15'h0000, st.save};
				REG_BANK:        next_st.rdata = {15'h0000, st.bank_sel};
				REG_KEY:         next_st.rdata = st.key;
				REG_ALM_MASK:    next_st.rdata = st.mask;
				REG_DISP_TIME:   next_st.rdata = {11'h000, st.disp_time};
				REG_STATUS:      next_st.rdata = {8'h00, st.bk_pend, st.idle, st.alm_factory, st.alm_verify,
				                                  st.refused, st.busy, st.online, st.ready};
				REG_PADDR:       next_st.rdata = {12'h000, st.paddr};
				REG_PDATA:       next_st.rdata = st.work[st.paddr];
				REG_FACT_REV:    next_st.rdata = st.fact_rev;
				REG_FACT_CAPT:   next_st.rdata = {14'h0000, st.fact_valid, st.capt};
				REG_ALARMS:      next_st.rdata = alarm_vec;
				default:         next_st.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st             <= '0;
			st.state       <= ST_COPY; // [R1]
			st.op          <= OP_BOOT;
			st.busy        <= 1'b1;
			st.sw_en       <= SW_EN_RST;
			st.run_en      <= RUN_EN_RST;
			st.mask        <= ALM_MASK_RST; // [R19]
			st.disp_time   <= DISP_DEF_S; // [R20]
			for (int b = 0; b < 2; b++)
				for (int i = 0; i < NW; i++)
					st.bank[b][i] <= DEFAULT_BASE | 16'(i);
		end else begin
			st <= next_st;
		end
	end

	assign rdata        = st.rdata;
	assign ready        = st.ready;
	assign online       = st.online;
	assign busy         = st.busy;
	assign display_idle = st.idle;

	chk_online_gate: assert property (@(posedge ref_clk) disable iff (!resetn) // [R18]
		st.online |-> st.ready && $past(st.s2.run_cmd) && $past(st.run_en))
		else $error("online without ready, run input and run enable");
	chk_ready_enables: assert property (@(posedge ref_clk) disable iff (!resetn) // [R15]
		st.ready |-> $past(st.sw_en && st.s2.ext_enable && !alarm_act))
		else $error("ready without enables or with alarm");
	chk_block_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // [R16]
		st.block && !rst_edge |=> st.block && !st.ready)
		else $error("ready latch released without alarm reset edge");
	chk_reset_level: assert property (@(posedge ref_clk) disable iff (!resetn) // [R17]
		rst_fn && $past(rst_fn) |-> !rst_edge)
		else $error("alarm reset acted on a held level");
	chk_load_stopped: assert property (@(posedge ref_clk) disable iff (!resetn) // [R5]
		st.state == ST_IDLE ##1 st.state == ST_COPY && st.op inside {OP_LOAD_NV, OP_LOAD_DEF, OP_FACT}
		|-> $past(!st.online))
		else $error("load started while running");
	chk_save_copy: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
		st.state == ST_COPY && st.op == OP_SAVE
		|=> st.bank[$past(st.bank_sel)][$past(st.idx)] == $past(st.work[st.idx]))
		else $error("save did not copy working word");
	chk_save_clear: assert property (@(posedge ref_clk) disable iff (!resetn) // [R22]
		st.state == ST_VERIFY && st.idx == 4'hF && !(bus.wr && bus.addr == REG_SAVE) |=> !st.save && !st.busy)
		else $error("save command not cleared after verify");
	chk_factory_alarm: assert property (@(posedge ref_clk) disable iff (!resetn) // [R14]
		st.state == ST_IDLE && !st.save && st.load_stored == LS_FACTORY && stopped && !st.fact_valid
		|=> st.alm_factory ##16 st.work[0] == DEFAULT_BASE)
		else $error("invalid factory image not flagged or defaults not loaded");
	chk_display_idle: assert property (@(posedge ref_clk) disable iff (!resetn) // [R20]
		$rose(st.idle) |-> $past(st.secs >= st.disp_time) && st.disp_time >= DISP_MIN_S)
		else $error("display went idle early");
	chk_disp_range: assert property (@(posedge ref_clk) disable iff (!resetn) // [R20]
		st.disp_time >= DISP_MIN_S && st.disp_time <= DISP_MAX_S)
		else $error("display time outside its range");
	chk_online_ready: assert property (@(posedge ref_clk) disable iff (!resetn) // [R18]
		st.online |-> st.ready)
		else $error("online while not ready");
	chk_alarm_drops: assert property (@(posedge ref_clk) disable iff (!resetn) // [R15]
		alarm_act |=> !st.ready)
		else $error("ready stayed high with an active alarm");
	chk_key_refuse: assert property (@(posedge ref_clk) disable iff (!resetn) // [R5]
		st.state == ST_IDLE && !st.save && st.load_def && st.load_stored == 2'h0 && !key_open && !bus.wr
		|=> !st.load_def && st.refused && st.state == ST_IDLE)
		else $error("load accepted with the key shut");
	chk_reserved_lock: assert property (@(posedge ref_clk) disable iff (!resetn) // [R21]
		st.state == ST_IDLE && bus.wr && bus.addr == REG_PDATA && RESERVED_MASK[st.paddr] && !key_open
		|=> st.work[$past(st.paddr)] == $past(st.work[st.paddr]))
		else $error("reserved word written with the key shut");
	chk_bank_off: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
		$changed(st.bank_sel) && !$past(bus.wr && bus.addr == REG_BANK) |-> $past(!st.ready && !st.online))
		else $error("bank switched while drive on");
	chk_bank_follow: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8]
		$fell(st.bk_pend) && !$past(bus.wr && bus.addr == REG_BANK)
		|-> st.bank_sel == $past(st.s2.bank_switch_input) && st.state == ST_COPY && st.op == OP_LOAD_NV)
		else $error("bank switch did not follow input or reload");
	chk_def_word: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
		st.state == ST_COPY && st.op == OP_LOAD_DEF
		|=> st.work[$past(st.idx)] == (DEFAULT_BASE | {12'h000, $past(st.idx)}))
		else $error("default load wrote a wrong word");
	chk_def_clear: assert property (@(posedge ref_clk) disable iff (!resetn) // [R22]
		st.state == ST_COPY && st.op == OP_LOAD_DEF && st.idx == 4'hF && !(bus.wr && bus.addr == REG_LOAD_DEF)
		|=> !st.load_def && !st.busy)
		else $error("default load command not cleared");
	chk_fact_match: assert property (@(posedge ref_clk) disable iff (!resetn) // [R11]
		st.state == ST_COPY && st.op == OP_FACT && st.fact_valid
		&& st.fact_rev == FW_REV && CORE_MASK[st.idx]
		|=> st.work[$past(st.idx)] == $past(st.fact[st.idx]))
		else $error("matching revision did not restore factory word");
	chk_fact_app: assert property (@(posedge ref_clk) disable iff (!resetn) // [R13]
		st.state == ST_COPY && st.op == OP_FACT && !CORE_MASK[st.idx]
		|=> st.work[$past(st.idx)] == (DEFAULT_BASE | {12'h000, $past(st.idx)}))
		else $error("factory restore left an application word off default");
endmodule : dpsrc_top
`default_nettype wire

// *** hdl/dpsrc_pkg.sv ***
/*
 * Package for the drive parameter store and run control block: register
 * indices, reset values, field layouts, timing constants, states and carriers.
 * Assumes a single 125 MHz system clock and a plain one-cycle register port.
 */
`default_nettype none
package dpsrc_pkg;
	localparam int NW = 16;
	typedef logic [15:0]          dpsrc_word_t;
	typedef logic [NW-1:0][15:0]  dpsrc_mem_t;

	// Register indices
	localparam logic [7:0] REG_CTRL        = 8'h00;
	localparam logic [7:0] REG_LOAD_DEF    = 8'h01;
	localparam logic [7:0] REG_LOAD_STORED = 8'h02;
	localparam logic [7:0] REG_SAVE        = 8'h03;
	localparam logic [7:0] REG_BANK        = 8'h04;
	localparam logic [7:0] REG_KEY         = 8'h05;
	localparam logic [7:0] REG_ALM_MASK    = 8'h06;
	localparam logic [7:0] REG_DISP_TIME   = 8'h07;
	localparam logic [7:0] REG_STATUS      = 8'h08;
	localparam logic [7:0] REG_PADDR       = 8'h09;
	localparam logic [7:0] REG_PDATA       = 8'h0A;
	localparam logic [7:0] REG_FACT_REV    = 8'h0B;
	localparam logic [7:0] REG_FACT_CAPT   = 8'h0C;
	localparam logic [7:0] REG_ALARMS      = 8'h0D;

	// Control field positions
	localparam int CTRL_SW_EN  = 0;
	localparam int CTRL_RUN_EN = 1;
	localparam int CTRL_AL_RST = 2;

	// Reset values and selector codes
	localparam logic        SW_EN_RST     = 1'b1;
	localparam logic        RUN_EN_RST    = 1'b1;
	localparam dpsrc_word_t ALM_MASK_RST  = 16'hFFFF;
	localparam dpsrc_word_t KEY_VALUE     = 16'h0000;
	localparam logic [1:0]  LS_NV         = 2'h1;
	localparam logic [1:0]  LS_FACTORY    = 2'h2;
	localparam dpsrc_word_t CORE_MASK     = 16'h00FF;
	localparam dpsrc_word_t PROTECT_MASK  = 16'h0031;
	localparam dpsrc_word_t RESERVED_MASK = 16'h00F0;
	localparam dpsrc_word_t DEFAULT_BASE  = 16'h1000;
	// Firmware revision of this build, arbitrary value
	localparam dpsrc_word_t FW_REV        = 16'h0101;

	// Alarm vector bits
	localparam int AL_VERIFY  = 0;
	localparam int AL_FACTORY = 1;

	// Timing
	localparam int          CLK_PERIOD_NS   = 8;
	localparam int          SECOND_NS       = 1_000_000_000;
	localparam int          CYCLES_PER_SEC  = SECOND_NS / CLK_PERIOD_NS;
	localparam logic [4:0]  DISP_MIN_S      = 5'd3;
	localparam logic [4:0]  DISP_MAX_S      = 5'd20;
	localparam logic [4:0]  DISP_DEF_S      = 5'd10;

	typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_VERIFY} dpsrc_state_t;
	typedef enum logic [2:0] {OP_BOOT, OP_LOAD_NV, OP_LOAD_DEF, OP_SAVE, OP_FACT, OP_CAPT} dpsrc_op_t;

	typedef struct packed {
		logic [7:0]  addr;
		dpsrc_word_t wdata;
		logic        wr;
		logic        rd;
	} dpsrc_bus_t;

	typedef struct packed {
		logic        ext_enable;
		logic        run_cmd;
		logic        alarm_reset;
		logic        bank_switch_input;
		logic [13:0] alarm_cause;
	} dpsrc_pins_t;

	function automatic dpsrc_word_t default_word(input logic [3:0] i);
		default_word = DEFAULT_BASE | {12'h000, i};
	endfunction : default_word
endpackage : dpsrc_pkg
`default_nettype wire

// *** dv/dpsrc_pins_model.sv ***
/*
 * Model of the drive's external logic inputs: enable, run, alarm reset,
 * bank select and alarm causes. Assumes the bench sets the wanted levels in lvl
 * right after a rising edge; the model launches them on the next edge.
 */
`default_nettype none
module dpsrc_pins_model (
	input  wire logic                  ref_clk,
	output var  dpsrc_pkg::dpsrc_pins_t pins
);
	import dpsrc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	dpsrc_pins_t lvl = '0;
	initial pins = '0;
	always @(posedge ref_clk) begin
		pins <= lvl;
	end
endmodule : dpsrc_pins_model
`default_nettype wire

// *** dv/tb_top.sv ***
/*
 * Self-checking bench for the parameter store and run control block.
 * Assumes the one-cycle register port and a shortened second of 10 cycles.
 */
`default_nettype none
module tb_top;
	import dpsrc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CPS = 10;
	logic        ref_clk = 1'b0;
	logic        resetn  = 1'b0;
	dpsrc_bus_t  bus     = '0;
	dpsrc_pins_t pins;
	dpsrc_pins_t pv      = '0;
	logic [15:0] rdata;
	logic        ready;
	logic        online;
	logic        busy;
	logic        display_idle;
	int          n_errors = 0;
	int          n_tests  = 0;
	int          cyc      = 0;

	always #4 ref_clk = ~ref_clk;

	dpsrc_pins_model pm (.ref_clk(ref_clk), .pins(pins));
	dpsrc_top #(.CYCLES_PER_SEC_P(CPS)) uut (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .pins(pins),
		.rdata(rdata), .ready(ready), .online(online), .busy(busy), .display_idle(display_idle));

	task automatic tally_and_finish();
		$display("Comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic cmp(input string what, input dpsrc_word_t exp, input dpsrc_word_t got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic cmpb(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : cmpb

	task automatic wr(input logic [7:0] a, input dpsrc_word_t d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rr(input logic [7:0] a, input dpsrc_word_t exp, input string what);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		@(negedge ref_clk);
		cmp(what, exp, rdata);
	endtask : rr

	task automatic wd(input logic [3:0] i, input dpsrc_word_t exp, input string what);
		wr(REG_PADDR, {12'h000, i});
		rr(REG_PDATA, exp, what);
	endtask : wd

	task automatic pw(input logic [3:0] i, input dpsrc_word_t d);
		wr(REG_PADDR, {12'h000, i});
		wr(REG_PDATA, d);
	endtask : pw

	task automatic setp();
		@(posedge ref_clk);
		pm.lvl <= pv;
		repeat (8) @(posedge ref_clk);
	endtask : setp

	task automatic wait_idle();
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge ref_clk);
		cmpb("busy end", 1'b0, busy);
	endtask : wait_idle

	task automatic cmd(input logic [7:0] a, input dpsrc_word_t d);
		wr(a, d);
		wait_idle();
		rr(a, 16'h0000, "command cleared");
	endtask : cmd

	task automatic t_reset();
		repeat (8) @(posedge ref_clk);
		cmpb("busy in reset", 1'b1, busy);
		resetn <= 1'b1;
		wait_idle();
		rr(REG_CTRL, 16'h0003, "ctrl reset");
		rr(REG_ALM_MASK, ALM_MASK_RST, "alarm mask");
		rr(REG_DISP_TIME, 16'h000A, "display time");
		rr(REG_BANK, 16'h0000, "bank reset");
		rr(8'h20, 16'h0000, "unmapped");
		wd(4'h3, 16'h1003, "boot word");
	endtask : t_reset

	task automatic t_ready();
		logic sw;
		logic ren;
		for (int i = 0; i < 16; i++) begin
			sw = i[2];
			ren = i[3];
			pv.ext_enable = i[0];
			pv.run_cmd = i[1];
			wr(REG_CTRL, {14'h0000, ren, sw});
			setp();
			cmpb("ready", i[0] & sw, ready);
			cmpb("online", i[0] & sw & i[1] & ren, online);
		end
	endtask : t_ready

	task automatic t_mem();
		pv.run_cmd = 1'b0;
		setp();
		pw(4'h8, 16'h1234);
		cmd(REG_SAVE, 16'h0001);
		rr(REG_STATUS, 16'h0001, "status after save");
		pw(4'h8, 16'h5555);
		cmd(REG_LOAD_STORED, {14'h0000, LS_NV});
		wd(4'h8, 16'h1234, "load stored");
		cmd(REG_LOAD_DEF, 16'h0001);
		wd(4'h8, 16'h1008, "load default");
		pv.run_cmd = 1'b1;
		setp();
		pw(4'h8, 16'h7777);
		cmd(REG_LOAD_DEF, 16'h0001);
		wd(4'h8, 16'h7777, "load while online");
		rr(REG_STATUS, 16'h000B, "refused flag");
		cmd(REG_SAVE, 16'h0001);
		pv.run_cmd = 1'b0;
		setp();
		wr(REG_KEY, 16'h0001);
		pw(4'h4, 16'hBEEF);
		wd(4'h4, 16'h1004, "reserved locked");
		cmd(REG_LOAD_DEF, 16'h0001);
		wd(4'h8, 16'h7777, "load with key shut");
		wr(REG_KEY, 16'h0000);
		cmd(REG_LOAD_STORED, {14'h0000, LS_NV});
		wd(4'h8, 16'h7777, "save while online");
	endtask : t_mem

	task automatic t_alarm();
		pv.alarm_cause = 14'h0001;
		setp();
		cmpb("ready on alarm", 1'b0, ready);
		pv.alarm_reset = 1'b1;
		setp();
		pv.alarm_cause = 14'h0000;
		setp();
		cmpb("ready held level", 1'b0, ready);
		pv.alarm_reset = 1'b0;
		setp();
		pv.alarm_reset = 1'b1;
		setp();
		cmpb("ready after edge", 1'b1, ready);
		pv.alarm_reset = 1'b0;
		setp();
	endtask : t_alarm

	task automatic t_bank();
		pv.ext_enable = 1'b0;
		setp();
		pw(4'h8, 16'h4321);
		pv.bank_switch_input = 1'b1;
		setp();
		wait_idle();
		rr(REG_BANK, 16'h0001, "bank follows input");
		wd(4'h8, 16'h1008, "bank 1 reload");
		pv.ext_enable = 1'b1;
		pv.bank_switch_input = 1'b0;
		setp();
		repeat (40) @(posedge ref_clk);
		rr(REG_BANK, 16'h0001, "no switch when ready");
		pv.ext_enable = 1'b0;
		setp();
		wait_idle();
		rr(REG_BANK, 16'h0000, "bank back");
		wd(4'h8, 16'h7777, "bank 0 reload");
	endtask : t_bank

	task automatic t_fact();
		pw(4'h9, 16'h4444);
		cmd(REG_LOAD_STORED, {14'h0000, LS_FACTORY});
		rr(REG_STATUS, 16'h0020, "factory alarm");
		wd(4'h9, 16'h1009, "invalid image");
		wr(REG_CTRL, 16'h0007);
		rr(REG_STATUS, 16'h0000, "alarm cleared");
		pw(4'h0, 16'hAAAA);
		pw(4'h1, 16'hBBBB);
		wr(REG_FACT_CAPT, 16'h0001);
		wait_idle();
		rr(REG_FACT_CAPT, 16'h0002, "capture valid");
		pw(4'h1, 16'h0000);
		pw(4'h9, 16'h4444);
		wr(REG_KEY, 16'h0001);
		wr(REG_FACT_REV, FW_REV);
		cmd(REG_LOAD_STORED, {14'h0000, LS_FACTORY});
		wd(4'h1, 16'hBBBB, "core restored");
		wd(4'h9, 16'h1009, "app default");
		wr(REG_FACT_REV, 16'h0202);
		pw(4'h0, 16'h0000);
		cmd(REG_LOAD_STORED, {14'h0000, LS_FACTORY});
		wd(4'h0, 16'hAAAA, "protected kept");
		wd(4'h1, 16'h1001, "core default");
		wr(REG_KEY, 16'h0000);
	endtask : t_fact

	task automatic t_disp();
		wr(REG_DISP_TIME, 16'h0019);
		rr(REG_DISP_TIME, 16'h0014, "display clamp");
		wr(REG_DISP_TIME, 16'h0003);
		repeat (20) @(posedge ref_clk);
		cmpb("display busy", 1'b0, display_idle);
		repeat (20) @(posedge ref_clk);
		cmpb("display idle", 1'b1, display_idle);
	endtask : t_disp

	initial begin
		t_reset();
		t_ready();
		t_mem();
		t_alarm();
		t_bank();
		t_fact();
		t_disp();
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
